// File: bench/dpc_far_side.sv
/*
  far side model: drive status levels and data channel events.
  assumes: same clock as the block; the bench calls its tasks.
*/
`timescale 1ns/1ps
module dpc_far_side (
  input  wire logic        i_sys_clk,   // system clock
  input  wire logic        i_attach,    // channel held by control
  input  wire logic        i_cw_req,    // control word write request
  output logic      [7:0]  o_lvl,       // big, heads, online, unsafe, prot, attn, pwr, par ok
  output logic      [10:0] o_ev,        // one-cycle channel and disk events
  output logic             o_cw_stored  // control word stored
);
  int cw_dly = 3;  // cycles from request to store
  int cnt    = 0;  // store countdown
  initial begin
    o_lvl       = 8'h87;
    o_ev        = '0;
    o_cw_stored = 1'b0;
  end
  // channel stores a control word a few cycles after being asked
  always @(posedge i_sys_clk) begin
    o_cw_stored <= (cnt == 1);
    if (i_cw_req) begin
      cnt <= cw_dly;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
  end
  // one event pulse; a disconnected channel drops events 0 to 3 but still sends continue (4)
  task automatic pulse(input int k);
    @(posedge i_sys_clk);
    if (k > 3 || i_attach) begin
      o_ev[k] <= 1'b1;
    end
    // a continue request only means anything at the cylinder end
    if (k == 4) begin
      o_ev[10] <= 1'b1;
    end
    @(posedge i_sys_clk);
    o_ev <= '0;
    #1;
  endtask : pulse
  // new drive levels, seen by the block one edge later
  task automatic set_lvl(input logic [7:0] v);
    @(posedge i_sys_clk);
    o_lvl <= v;
    @(posedge i_sys_clk);
    #1;
  endtask : set_lvl
endmodule : dpc_far_side

// File: bench/dpc_status_flags_tb.sv
/*
  self-checking bench for the status flag block.
  assumes: dpc_pkg, dpc_status_flags and dpc_far_side are compiled first.
*/
`timescale 1ns/1ps
module dpc_status_flags_tb
  import dpc_pkg::*;
;
  localparam logic [7:0] GOOD = 8'h87;  // big drive ready, address parity good
  logic        sys_clk = 1'b0;  // system clock
  logic        rst_n   = 1'b0;  // reset, active low
  logic        cond_wr = 1'b0;  // condition write strobe
  logic        cmd_wr  = 1'b0;  // command write strobe
  logic [35:0] wdata   = '0;    // write operand
  logic [35:0] status;          // status word
  logic        irq;             // interrupt request
  logic [2:0]  irq_chan;        // interrupt channel
  logic        attach;          // channel held
  logic        cw_req;          // control word request
  logic [7:0]  lvl;             // far side levels
  logic [10:0] ev;              // far side events
  logic        cw_stored;       // control word stored
  int          n_errors = 0;    // mismatches
  int          checked  = 0;    // comparisons
  int          k;               // loop index
  // refusal and boundary table: function, surface, sector, levels, status bit
  int         t_fn  [12] = '{0, 0, 0, 0, 1, 3, 0, 0, 0, 0, 0, 0};
  int         t_su  [12] = '{0, 0, 24, 12, 0, 0, 0, 0, 0, 23, 11, 0};
  int         t_se  [12] = '{12, 5, 0, 0, 0, 0, 0, 0, 0, 11, 4, 0};
  logic [7:0] t_lv  [12] = '{8'h87, 8'h86, 8'h87, 8'h86, 8'h97, 8'h97, 8'h85, 8'h83, 8'h8f, 8'h87, 8'h86, 8'hc7};
  int         t_pos [12] = '{28, 28, 29, 29, 26, 26, 25, 25, 25, 31, 31, 20};
  always #10 sys_clk = ~sys_clk;
  dpc_status_flags dut (
    .i_sys_clk(sys_clk), .i_rst_n(rst_n), .i_cond_wr(cond_wr), .i_cmd_wr(cmd_wr), .i_wdata(wdata),
    .o_status(status), .o_irq(irq), .o_irq_chan(irq_chan), .i_drive_big(lvl[0]), .i_heads_in_pos(lvl[1]),
    .i_on_line(lvl[2]), .i_file_unsafe(lvl[3]), .i_write_prot(lvl[4]), .i_attention(lvl[5]),
    .i_pwr_bad(lvl[6]), .i_ch_cw_par(ev[0]), .i_ch_data_par(ev[1]), .i_ch_late(ev[2]), .i_ch_nxm(ev[3]),
    .i_ch_cw_stored(cw_stored), .i_ch_continue(ev[4]), .i_sec_par(ev[5]), .i_dsk_par(ev[6]),
    .i_addr_match(ev[7]), .i_addr_par_ok(lvl[7]), .i_eot(ev[8]), .i_field_end(ev[9]),
    .i_cyl_end(ev[10]), .o_ch_attach(attach), .o_cw_req(cw_req));
  dpc_far_side u_far (
    .i_sys_clk(sys_clk), .i_attach(attach), .i_cw_req(cw_req), .o_lvl(lvl), .o_ev(ev), .o_cw_stored(cw_stored));
  // ***************************************************************
  // access tasks and comparisons
  // ***************************************************************
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : print_verdict
  task automatic chk(input string nm, input logic [35:0] e, input logic [35:0] g);
    checked++;
    if (g !== e) begin
      $display("mismatch %s expected %h seen %h", nm, e, g);
      n_errors++;
    end
  endtask : chk
  task automatic cb(input int n, input logic e);
    chk($sformatf("status bit %0d", n), {35'h0, e}, {35'h0, status[35-n]});
  endtask : cb
  // one strobe of either write; result is visible when the task returns
  task automatic wr(input logic c, input logic [35:0] d);
    @(posedge sys_clk);
    cond_wr <= c;
    cmd_wr  <= ~c;
    wdata   <= d;
    @(posedge sys_clk);
    cond_wr <= 1'b0;
    cmd_wr  <= 1'b0;
    #1;
  endtask : wr
  function automatic logic [35:0] cmd(int fn, int su, int se, logic [2:0] ns);
    logic [35:0] w;
    w = '0;
    w[CMD_FN_HI -: 3]   = fn[2:0];
    w[CMD_SURF_HI -: 5] = su[4:0];
    w[CMD_SEC_HI -: 5]  = se[4:0];
    w[CMD_NOSTOP_SEC]   = ns[2];
    w[CMD_NOSTOP_CHD]   = ns[1];
    w[CMD_NOSTOP_DSK]   = ns[0];
    return w;
  endfunction : cmd
  // condition word keeping channel 5, with one function bit
  function automatic logic [35:0] cc(int i);
    return (36'h1 << i) | 36'h5;
  endfunction : cc
  // ***************************************************************
  // main sequence
  // ***************************************************************
  initial begin
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    #1;
    chk("status", '0, status);
    chk("irq_chan", '0, {33'h0, irq_chan});
    wr(1'b1, 36'h5);
    chk("irq_chan", 36'h5, {33'h0, irq_chan});
    u_far.set_lvl(8'ha7);
    chk("irq", 36'h1, {35'h0, irq});
    u_far.set_lvl(GOOD);
    wr(1'b0, cmd(FN_READ, 0, 0, 3'b000));
    cb(31, 1'b1);
    chk("attach", 36'h1, {35'h0, attach});
    wr(1'b0, cmd(FN_WRITE, 0, 0, 3'b000));
    cb(27, 1'b1);
    cb(32, 1'b0);
    u_far.pulse(6);
    cb(17, 1'b1);
    cb(24, 1'b1);
    cb(31, 1'b0);
    cb(32, 1'b1);
    chk("attach", '0, {35'h0, attach});
    chk("irq", 36'h1, {35'h0, irq});
    wr(1'b1, cc(CW_CLR_PAR));
    cb(17, 1'b0);
    wr(1'b0, cmd(FN_READ, 0, 0, 3'b000));
    cb(27, 1'b0);
    wr(1'b1, cc(CW_STOP));
    cb(31, 1'b0);
    // errors that release the channel and finish the field first
    foreach (t_fn[i]) begin
      if (i < 4) begin
        wr(1'b0, cmd(FN_WRITE, 0, 0, 3'b000));
        u_far.pulse(i);
        cb(i == 0 ? 14 : i == 1 ? 16 : i == 2 ? 22 : 23, 1'b1);
        chk("attach", '0, {35'h0, attach});
        cb(31, 1'b1);
        u_far.pulse(9);
        cb(31, 1'b0);
      end
    end
    wr(1'b0, cmd(FN_READ, 0, 0, 3'b100));
    cb(23, 1'b0);
    u_far.pulse(5);
    cb(15, 1'b1);
    cb(31, 1'b1);
    u_far.set_lvl(8'h07);
    u_far.pulse(7);
    cb(18, 1'b0);
    u_far.set_lvl(GOOD);
    u_far.pulse(7);
    cb(18, 1'b1);
    u_far.pulse(10);
    u_far.pulse(4);
    cb(19, 1'b1);
    cb(31, 1'b0);
    wr(1'b0, cmd(FN_READ, 0, 0, 3'b000));
    u_far.pulse(5);
    cb(31, 1'b0);
    wr(1'b0, cmd(FN_READ, 0, 0, 3'b000));
    u_far.pulse(8);
    u_far.pulse(8);
    cb(21, 1'b0);
    u_far.pulse(8);
    cb(21, 1'b1);
    cb(31, 1'b0);
    wr(1'b0, cmd(FN_READ, 0, 0, 3'b000));
    u_far.set_lvl(8'h85);
    cb(25, 1'b1);
    cb(31, 1'b0);
    // refused starts and accepted boundary addresses
    foreach (t_fn[i]) begin
      u_far.set_lvl(t_lv[i]);
      wr(1'b0, cmd(t_fn[i], t_su[i], t_se[i], 3'b000));
      cb(t_pos[i], 1'b1);
      cb(32, t_pos[i] != 31);
      if (t_pos[i] == 31) begin
        wr(1'b1, cc(CW_STOP));
      end
    end
    u_far.set_lvl(GOOD);
    wr(1'b1, cc(CW_CLR_PWR));
    wr(1'b0, cmd(FN_READ, 0, 0, 3'b000));
    u_far.set_lvl(8'hc7);
    cb(20, 1'b1);
    cb(31, 1'b1);
    u_far.pulse(9);
    cb(31, 1'b0);
    u_far.set_lvl(GOOD);
    wr(1'b1, cc(CW_REQ_CW));
    k = 0;
    while (status[35-30] !== 1'b1 && k < 20) begin
      @(posedge sys_clk);
      #1;
      k++;
    end
    if (k == 20) begin
      n_errors++;
      print_verdict();
    end
    cb(30, 1'b1);
    wr(1'b0, cmd(FN_READ, 0, 0, 3'b000));
    cb(30, 1'b0);
    print_verdict();
  end
  // cut a hang short
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_errors++;
    print_verdict();
  end
endmodule : dpc_status_flags_tb

// File: design/dpc_pkg.sv
/*
  package for the disk pack control unit status flag block.
  assumes a 36-bit word numbered 0 (msb) to 35 (lsb), as the processor does.
*/
package dpc_pkg;
  // ***************************************************************
  // word width and bit positions (index = 35 - documented bit)
  // ***************************************************************
  localparam int WORD_W         = 36;
  localparam int POS_CW_PAR     = 35 - 14;  // control word parity
  localparam int POS_SEC_PAR    = 35 - 15;  // sector parity
  localparam int POS_CHD_PAR    = 35 - 16;  // channel data parity
  localparam int POS_DSK_PAR    = 35 - 17;  // disk word parity
  localparam int POS_XFER       = 35 - 18;  // block transfer active
  localparam int POS_CYL_OVF    = 35 - 19;  // cylinder overflow
  localparam int POS_PWR_FAIL   = 35 - 20;  // power failure
  localparam int POS_SRCH_ERR   = 35 - 21;  // search error
  localparam int POS_LATE       = 35 - 22;  // data late
  localparam int POS_NXM        = 35 - 23;  // no such memory
  localparam int POS_PAR_ANY    = 35 - 24;  // any parity error
  localparam int POS_NRDY       = 35 - 25;  // not ready
  localparam int POS_ILL_WR     = 35 - 26;  // illegal write
  localparam int POS_BUSY_CMD   = 35 - 27;  // command while busy
  localparam int POS_SEC_ADR    = 35 - 28;  // sector address error
  localparam int POS_SURF_ADR   = 35 - 29;  // surface address error
  localparam int POS_CW_DONE    = 35 - 30;  // control word written
  localparam int POS_BUSY       = 35 - 31;  // busy
  localparam int POS_DONE       = 35 - 32;  // done
  localparam int POS_CHAN_LO    = 35 - 35;  // interrupt channel lsb
  // condition write operand bit positions
  localparam int CW_CLR_PWR     = 35 - 20;
  localparam int CW_CLR_SRCH    = 35 - 21;
  localparam int CW_CLR_LATE    = 35 - 22;
  localparam int CW_CLR_NXM     = 35 - 23;
  localparam int CW_CLR_PAR     = 35 - 24;
  localparam int CW_CLR_ILL     = 35 - 26;
  localparam int CW_CLR_BUSYCMD = 35 - 27;
  localparam int CW_CLR_SEC     = 35 - 28;
  localparam int CW_CLR_SURF    = 35 - 29;
  localparam int CW_REQ_CW      = 35 - 30;
  localparam int CW_STOP        = 35 - 31;
  localparam int CW_CLR_DONE    = 35 - 32;
  // command word fields
  localparam int CMD_FN_HI      = 35 - 0;
  localparam int CMD_SURF_HI    = 35 - 14;
  localparam int CMD_SEC_HI     = 35 - 19;
  localparam int CMD_NOSTOP_SEC = 35 - 24;
  localparam int CMD_NOSTOP_CHD = 35 - 25;
  localparam int CMD_NOSTOP_DSK = 35 - 26;
  // ***************************************************************
  // function codes and address limits
  // ***************************************************************
  localparam logic [2:0] FN_READ   = 3'h0;
  localparam logic [2:0] FN_WRITE  = 3'h1;
  localparam logic [2:0] FN_FORMAT = 3'h3;
  localparam logic [4:0] SEC_MAX_BIG   = 5'h0_b;
  localparam logic [4:0] SEC_MAX_SMALL = 5'h0_4;
  localparam logic [4:0] SURF_MAX_BIG  = 5'h1_7;
  localparam logic [4:0] SURF_MAX_SMALL= 5'h0_b;
  localparam int SEARCH_EOT_LIMIT = 3;
  // reset values
  localparam logic [2:0] CHAN_RESET = 3'h0;
  // controller state
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,  // not busy
    ST_RUN   = 3'b010,  // busy, channel attached
    ST_FIELD = 3'b100   // busy, finishing field then stop
  } dpc_state_t;
endpackage : dpc_pkg

// File: design/dpc_status_flags.sv
/*
  status word, flag and termination logic of the disk pack control unit.
  assumes: processor strobes and operands synchronous to i_sys_clk; channel
  and drive events are one-cycle pulses or levels from logic on that clock.
*/
`timescale 1ns/1ps
module dpc_status_flags
  import dpc_pkg::*;
(
  input  wire logic              i_sys_clk,       // system clock
  input  wire logic              i_rst_n,         // sync reset, active low
  input  wire logic              i_cond_wr,       // condition write strobe
  input  wire logic              i_cmd_wr,        // command write strobe
  input  wire logic [WORD_W-1:0] i_wdata,         // operand of either write
  output logic      [WORD_W-1:0] o_status,        // status word for status read
  output logic                   o_irq,           // request on o_irq_chan
  output logic      [2:0]        o_irq_chan,      // assigned channel
  input  wire logic              i_drive_big,     // selected drive is larger type
  input  wire logic              i_heads_in_pos,  // drive heads positioned
  input  wire logic              i_on_line,       // drive on line
  input  wire logic              i_file_unsafe,   // drive malfunction
  input  wire logic              i_write_prot,    // pack write protected
  input  wire logic              i_attention,     // any attention flag set
  input  wire logic              i_pwr_bad,       // supply out of tolerance
  input  wire logic              i_ch_cw_par,     // channel: control word parity
  input  wire logic              i_ch_data_par,   // channel: data word parity
  input  wire logic              i_ch_late,       // channel missed a word
  input  wire logic              i_ch_nxm,        // channel: memory timeout
  input  wire logic              i_ch_cw_stored,  // channel stored control word
  input  wire logic              i_ch_continue,   // channel asks past cylinder end
  input  wire logic              i_sec_par,       // sector parity bad
  input  wire logic              i_dsk_par,       // disk word parity bad
  input  wire logic              i_addr_match,    // sector address matched
  input  wire logic              i_addr_par_ok,   // address word parity good
  input  wire logic              i_eot,           // end of track seen
  input  wire logic              i_field_end,     // current data field done
  input  wire logic              i_cyl_end,       // last sector of cylinder done
  output logic                   o_ch_attach,     // channel held by control
  output logic                   o_cw_req         // control word write request
);
  // all assertions below run on the system clock and rest during reset
  default clocking a_clk @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rst_n);
  // ***************************************************************
  // flags and state
  // ***************************************************************
  dpc_state_t state;                 // controller state
  logic [3:0] par_flags;             // bits 14..17
  logic       xfer, cyl_ovf, srch_err, late, nxm;
  logic       nrdy_f, ill_wr, busy_cmd, sec_adr, surf_adr, cw_done;
  logic       done, intr, pwr_f;
  logic [1:0] eot_cnt;               // end-of-track count in search
  logic [2:0] nostop;                // sec, chd, dsk stop disables
  logic       busy;
  logic       accept;                // command write taken
  logic       proc_fn;               // command is disk processing
  logic       sec_bad, surf_bad, not_ready, start_err;
  logic       stop_now, stop_field, term;
  logic       err_set;               // refused start or termination, sets done
  logic       cmd_clr;

  assign busy      = (state != ST_IDLE);
  assign accept    = i_cmd_wr && !busy;
  assign cmd_clr   = accept;
  assign proc_fn   = (i_wdata[CMD_FN_HI -: 3] == FN_READ) || (i_wdata[CMD_FN_HI -: 3] == FN_WRITE)
                  || (i_wdata[CMD_FN_HI -: 3] == FN_FORMAT);
  assign sec_bad   = i_wdata[CMD_SEC_HI -: 5]  > (i_drive_big ? SEC_MAX_BIG : SEC_MAX_SMALL);
  assign surf_bad  = i_wdata[CMD_SURF_HI -: 5] > (i_drive_big ? SURF_MAX_BIG : SURF_MAX_SMALL);
  assign not_ready = !i_heads_in_pos || !i_on_line || i_file_unsafe;
  logic wr_fn;
  assign wr_fn     = (i_wdata[CMD_FN_HI -: 3] == FN_WRITE) || (i_wdata[CMD_FN_HI -: 3] == FN_FORMAT);
  assign start_err = accept && proc_fn
                  && (pwr_f || i_pwr_bad || not_ready || (wr_fn && i_write_prot) || sec_bad || surf_bad);

  // immediate stop causes while busy
  assign stop_now = busy && (
         (i_sec_par && !nostop[2])
      || (i_dsk_par && !nostop[0])
      || (i_ch_continue && state == ST_RUN && i_cyl_end)
      || (i_eot && !xfer && eot_cnt == 2'(SEARCH_EOT_LIMIT - 1))
      || not_ready || i_write_prot && ill_wr
      || (i_cond_wr && i_wdata[CW_STOP]));
  // causes that release the channel and finish the field
  assign stop_field = (state == ST_RUN) && (i_ch_cw_par || i_ch_nxm || i_ch_late
                     || (i_ch_data_par && !nostop[1]) || i_pwr_bad);
  assign term = stop_now || (state == ST_FIELD && i_field_end);
  assign err_set = start_err || term;

  // ***************************************************************
  // controller state machine
  // ***************************************************************
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      state <= ST_IDLE;
    end else begin
      unique case (state)
        ST_IDLE:  if (accept && proc_fn && !start_err) state <= ST_RUN;
        ST_RUN:   begin
          if (term) state <= ST_IDLE;
          else if (stop_field) state <= ST_FIELD;
        end
        ST_FIELD: if (term) state <= ST_IDLE;
        default:  state <= ST_IDLE;
      endcase
    end
  end

  // channel held only in run state, dropped at termination or on entering the field stop state
  assign o_ch_attach = (state == ST_RUN);

  // ***************************************************************
  // command latched stop disables and search counter
  // ***************************************************************
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      nostop  <= 3'h0;
      eot_cnt <= 2'h0;
    end else begin
      if (accept) begin
        nostop  <= {i_wdata[CMD_NOSTOP_SEC], i_wdata[CMD_NOSTOP_CHD], i_wdata[CMD_NOSTOP_DSK]};
        eot_cnt <= 2'h0;
      end else if (busy && !xfer && i_eot) begin
        eot_cnt <= eot_cnt + 2'h1;
      end
    end
  end

  // ***************************************************************
  // error flags: set wins over clear
  // ***************************************************************
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      par_flags <= 4'h0;
      {cyl_ovf, srch_err, late, nxm, nrdy_f, ill_wr, sec_adr, surf_adr, cw_done} <= 9'h000;
    end else begin
      if (cmd_clr) begin
        par_flags <= 4'h0;
        {srch_err, late, nxm, ill_wr, sec_adr, surf_adr, cw_done} <= 7'h00;
      end else if (i_cond_wr) begin
        if (i_wdata[CW_CLR_PAR])  par_flags <= 4'h0;
        if (i_wdata[CW_CLR_SRCH]) srch_err  <= 1'b0;
        if (i_wdata[CW_CLR_LATE]) late      <= 1'b0;
        if (i_wdata[CW_CLR_NXM])  nxm       <= 1'b0;
        if (i_wdata[CW_CLR_ILL])  ill_wr    <= 1'b0;
        if (i_wdata[CW_CLR_SEC])  sec_adr   <= 1'b0;
        if (i_wdata[CW_CLR_SURF]) surf_adr  <= 1'b0;
        if (i_wdata[CW_REQ_CW])   cw_done   <= 1'b0;
      end
      if (busy) begin
        if (i_ch_cw_par)                  par_flags[3] <= 1'b1;
        if (i_sec_par)                    par_flags[2] <= 1'b1;
        if (i_ch_data_par)                par_flags[1] <= 1'b1;
        if (i_dsk_par)                    par_flags[0] <= 1'b1;
        if (i_ch_continue && i_cyl_end)   cyl_ovf      <= 1'b1;
        if (i_eot && !xfer && eot_cnt == 2'(SEARCH_EOT_LIMIT - 1)) srch_err <= 1'b1;
        if (i_ch_late)                    late         <= 1'b1;
        if (i_ch_nxm)                     nxm          <= 1'b1;
      end
      if (i_ch_cw_stored) cw_done <= 1'b1;
      if (accept && proc_fn) begin
        nrdy_f   <= not_ready;
        ill_wr   <= wr_fn && i_write_prot;
        sec_adr  <= sec_bad;
        surf_adr <= surf_bad;
      end else if (busy && not_ready) begin
        nrdy_f   <= 1'b1;
      end
      if (accept) cyl_ovf <= 1'b0;
    end
  end

  // ***************************************************************
  // command while busy and power failure
  // ***************************************************************
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      busy_cmd <= 1'b0;
      pwr_f    <= 1'b0;
    end else begin
      if (i_cmd_wr && busy)                                busy_cmd <= 1'b1;
      else if (accept || (i_cond_wr && i_wdata[CW_CLR_BUSYCMD])) busy_cmd <= 1'b0;
      if (i_pwr_bad)                                       pwr_f <= 1'b1;
      else if (i_cond_wr && i_wdata[CW_CLR_PWR])           pwr_f <= 1'b0;
    end
  end

  // ***************************************************************
  // transfer bit
  // ***************************************************************
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      xfer <= 1'b0;
    end else if (!busy || term) begin
      xfer <= 1'b0;
    end else if (i_addr_match && i_addr_par_ok) begin
      xfer <= 1'b1;
    end
  end

  // ***************************************************************
  // done, interrupt and channel assignment
  // ***************************************************************
  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      done       <= 1'b0;
      intr       <= 1'b0;
      o_irq_chan <= CHAN_RESET;
    end else begin
      if (err_set)                                     done <= 1'b1;
      else if (accept || (i_cond_wr && i_wdata[CW_CLR_DONE])) done <= 1'b0;
      // interrupt set with done or by attention while idle; it drops when done clears unless attention holds it
      if (err_set || (i_attention && !busy))           intr <= 1'b1;
      else if (!done || accept || (i_cond_wr && i_wdata[CW_CLR_DONE])) intr <= 1'b0;
      if (i_cond_wr) o_irq_chan <= i_wdata[POS_CHAN_LO +: 3];
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) o_cw_req <= 1'b0;
    else          o_cw_req <= i_cond_wr && i_wdata[CW_REQ_CW];
  end

  assign o_irq = intr;

  // ***************************************************************
  // status word
  // ***************************************************************
  always_comb begin
    o_status = '0;
    o_status[POS_CW_PAR -: 4]  = par_flags;
    o_status[POS_XFER]         = xfer;
    o_status[POS_CYL_OVF]      = cyl_ovf;
    o_status[POS_PWR_FAIL]     = pwr_f;
    o_status[POS_SRCH_ERR]     = srch_err;
    o_status[POS_LATE]         = late;
    o_status[POS_NXM]          = nxm;
    o_status[POS_PAR_ANY]      = |par_flags;
    o_status[POS_NRDY]         = nrdy_f;
    o_status[POS_ILL_WR]       = ill_wr;
    o_status[POS_BUSY_CMD]     = busy_cmd;
    o_status[POS_SEC_ADR]      = sec_adr;
    o_status[POS_SURF_ADR]     = surf_adr;
    o_status[POS_CW_DONE]      = cw_done;
    o_status[POS_BUSY]         = busy;
    o_status[POS_DONE]         = intr;                                    // bit 32 shows interrupt
    o_status[POS_CHAN_LO +: 3] = o_irq_chan;
  end

  // ***************************************************************
  // assertions on flag and termination behaviour
  // ***************************************************************
  // termination leaves the control idle with done set
  a_term_sets_done: assert property (term |=> !busy && done)
    else $error("termination did not clear busy and set done");

  // the stop bit of a condition write ends the operation at once
  a_stop_bit_ends: assert property ((busy && i_cond_wr && i_wdata[CW_STOP]) |=> !busy && done)
    else $error("stop condition write did not terminate");

  // done rising always raises the interrupt flag
  a_done_raises_irq: assert property ($rose(done) |-> o_irq)
    else $error("done set without interrupt");

  // a refused start never goes busy but reports done
  a_refused_start: assert property (start_err |=> !busy && done)
    else $error("refused command started or left done clear");

  // an accepted command clears the command-while-busy and parity flags
  a_accept_clears: assert property (accept |=> !busy_cmd && par_flags == 4'h0)
    else $error("accepted command left flags set");

  // a command while busy flags itself and leaves the operation running
  a_busy_cmd_flag: assert property ((i_cmd_wr && busy && !term && !stop_field) |=> busy_cmd && busy)
    else $error("command while busy not flagged or not ignored");

  // transfer bit only rises after a matched address with good parity
  a_xfer_needs_match: assert property ($rose(xfer) |-> $past(i_addr_match && i_addr_par_ok))
    else $error("transfer bit set without a good address match");

  // channel-side errors release the channel but keep the control busy
  a_field_release: assert property ((stop_field && !term) |=> !o_ch_attach && busy)
    else $error("channel error did not release channel and finish field");

  // the end of the data field finishes a pending termination
  a_field_end_term: assert property ((state == ST_FIELD && i_field_end) |=> !busy)
    else $error("field end did not terminate");

  // third end of track without a match gives a search error and stops
  a_search_limit: assert property ((busy && i_eot && !xfer && eot_cnt == 2'(SEARCH_EOT_LIMIT - 1))
                                   |=> srch_err && !busy)
    else $error("search did not stop at end-of-track limit");

  // continuing past the cylinder end sets overflow and stops
  a_cyl_overflow: assert property ((state == ST_RUN && i_ch_continue && i_cyl_end) |=> cyl_ovf && !busy)
    else $error("cylinder overflow not flagged");

  // stored control word always shows in the status word
  a_cw_stored_flag: assert property (i_ch_cw_stored |=> cw_done)
    else $error("control word written flag not set");

  // supply trouble always latches the power failure flag
  a_pwr_flag_set: assert property (i_pwr_bad |=> pwr_f)
    else $error("power failure flag not set");

  // each condition write loads the interrupt channel
  a_chan_load: assert property (i_cond_wr |=> o_irq_chan == $past(i_wdata[POS_CHAN_LO +: 3]))
    else $error("interrupt channel not loaded");
endmodule : dpc_status_flags
